// file: common/mbpd_pkg.sv
// Purpose: Shared constants for the muxed bus, decode and port block
// Assumes: One system clock that stands in for the oscillator input
// Notes:   Bus cycle timing is expressed in oscillator phases

package mbpd_pkg;

   // Oscillator period and the number of oscillator phases per bus cycle
   localparam int          MBPD_OSC_NS     = 100;
   localparam int          MBPD_PHASES     = 5;
   localparam logic [2:0]  MBPD_PH_LAST    = 3'h4;
   localparam logic [2:0]  MBPD_PH_AS      = 3'h0;   // Address strobe phase
   localparam logic [2:0]  MBPD_PH_DS      = 3'h2;   // First data phase

   // Address space defaults
   localparam int          MBPD_AW_DEF     = 13;
   localparam logic [15:0] MBPD_EXT_IO_DEF = 16'hfccc; // Ten external slots

   // On-chip locations in the low page
   localparam logic [6:0]  MBPD_A_PORTA    = 7'h00;
   localparam logic [6:0]  MBPD_A_PORTB    = 7'h01;
   localparam logic [6:0]  MBPD_A_DDRA     = 7'h04;
   localparam logic [6:0]  MBPD_A_DDRB     = 7'h05;
   localparam logic [6:0]  MBPD_A_TMR0     = 7'h08;
   localparam logic [6:0]  MBPD_A_TMR1     = 7'h09;
   localparam logic [6:0]  MBPD_RAM_BASE   = 7'h10;
   localparam int          MBPD_RAM_WORDS  = 112;
   localparam int          MBPD_INT_TOP    = 127;

   // Values after reset
   localparam logic [7:0]  MBPD_DDR_RST    = 8'h00;

   // Cycle kinds and start-up sequence
   typedef enum logic [1:0] {K_VEC, K_CPU, K_DUMMY} mbpd_kind_e;
   typedef enum logic [1:0] {M_VEC_HI, M_VEC_LO, M_RUN} mbpd_mode_e;

endpackage

// file: verilog/mbpd_core.sv
// Purpose: Multiplexed bus master, address decode and two 8-bit ports
// Assumes: clk_sys is the oscillator; core hands requests in one by one
// Notes:   On-chip reads ignore the bus; every pin input is synchronised

`timescale 1ns/1ps

module mbpd_core
   import mbpd_pkg::*;
#(
   parameter int          AW          = MBPD_AW_DEF,     // Address width
   parameter logic [15:0] EXT_IO_MASK = MBPD_EXT_IO_DEF  // Low external slots
)
(
   input  wire logic          clk_sys,          // Oscillator clock
   input  wire logic          reset,            // Sync reset, active high
   input  wire logic          cpu_req,          // Request pulse
   input  wire logic          cpu_write,        // Request is a write
   input  wire logic          cpu_fetch,        // Request is opcode fetch
   input  wire logic          cpu_irq_seq,      // Interrupt servicing
   input  wire logic          cpu_halt,         // Wait or stop state
   input  wire logic [AW-1:0] cpu_addr,         // Request address
   input  wire logic [7:0]    cpu_wdata,        // Request write data
   output logic               cpu_busy,         // Request held or running
   output logic               cpu_ack,          // Request done pulse
   output logic [7:0]         cpu_rdata,        // Read result
   output logic [AW-1:0]      start_addr,       // Fetched start vector
   output logic               start_valid,      // Start vector complete
   output logic               addr_strobe,      // Address strobe
   output logic               data_strobe,      // Data strobe
   output logic               read_write,       // High read, low write
   output logic [AW-9:0]      high_addr_lines,  // Upper address
   output logic               opcode_fetch_flag, // Load-instruction output
   input  wire logic [7:0]    muxed_addr_data_lines_in,  // Bus level
   output logic [7:0]         muxed_addr_data_lines_out, // Bus drive value
   output logic [7:0]         muxed_addr_data_lines_oe,  // Bus drive enable
   input  wire logic [7:0]    port_a_pins_in,   // Port A pin level
   output logic [7:0]         port_a_pins_out,  // Port A output latch
   output logic [7:0]         port_a_pins_oe,   // Port A direction
   input  wire logic [7:0]    port_b_pins_in,   // Port B pin level
   output logic [7:0]         port_b_pins_out,  // Port B output latch
   output logic [7:0]         port_b_pins_oe    // Port B direction
);

   // Only the two documented address widths are served
   if (AW != 13 && AW != 16)
   begin : g_bad_aw
      $error("AW must be 13 or 16");
   end

   localparam logic [AW-1:0] VEC_LO_A = {AW{1'b1}};
   localparam logic [AW-1:0] VEC_HI_A = {{(AW-1){1'b1}}, 1'b0};

   // Control state
   logic [2:0]    phase, next_phase;
   logic          active, next_active;
   mbpd_kind_e    kind, next_kind;
   mbpd_mode_e    mode, next_mode;
   logic [AW-1:0] cyc_addr, next_cyc_addr;     // Address of running cycle
   logic [7:0]    cyc_wdata, next_cyc_wdata;
   logic          cyc_write, next_cyc_write;
   logic          cyc_fetch, next_cyc_fetch;
   logic          cyc_irq, next_cyc_irq;
   logic          pend, next_pend;             // Request waiting
   logic [AW-1:0] p_addr, next_p_addr;
   logic [7:0]    p_wdata, next_p_wdata;
   logic          p_write, next_p_write;
   logic          p_fetch, next_p_fetch;
   logic          p_irq, next_p_irq;
   logic          next_busy, next_ack, next_sv;
   logic [7:0]    next_rdata;
   logic [AW-1:0] next_start;
   logic          next_as, next_ds, next_rw, next_li;
   logic [7:0]    next_bout, next_boe;
   logic          mem_we;                       // Internal store this edge

   // Storage behind the low page
   logic [7:0]    ddr_a, ddr_b, next_ddr_a, next_ddr_b;
   logic [7:0]    dat_a, dat_b, next_dat_a, next_dat_b;
   logic [7:0]    tmr0, tmr1, next_tmr0, next_tmr1;
   logic [7:0]    ram [MBPD_RAM_WORDS];

   // Synchronisers for every pin input
   logic [7:0]    bus_s1, bus_s2, pa_s1, pa_s2, pb_s1, pb_s2;

   // Internal versus external decode
   function automatic logic is_int(input logic [AW-1:0] a);
      logic r;
      r = (a <= AW'(MBPD_INT_TOP));
      if (a < AW'(16))
      begin
         r = !EXT_IO_MASK[a[3:0]];
      end
      return r;
   endfunction

   // Read of an on-chip location
   function automatic logic [7:0] int_rd(input logic [6:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         MBPD_A_PORTA: r = (ddr_a & dat_a) | (~ddr_a & pa_s2);
         MBPD_A_PORTB: r = (ddr_b & dat_b) | (~ddr_b & pb_s2);
         MBPD_A_DDRA:  r = ddr_a;
         MBPD_A_DDRB:  r = ddr_b;
         MBPD_A_TMR0:  r = tmr0;
         MBPD_A_TMR1:  r = tmr1;
         default:
         begin
            if (a >= MBPD_RAM_BASE)
            begin
               r = ram[a - MBPD_RAM_BASE];
            end
         end
      endcase
      return r;
   endfunction

   // Pin inputs pass two flops before anything reads them
   always_ff @(posedge clk_sys)
   begin
      bus_s1 <= muxed_addr_data_lines_in;
      bus_s2 <= bus_s1;
      pa_s1  <= port_a_pins_in;
      pa_s2  <= pa_s1;
      pb_s1  <= port_b_pins_in;
      pb_s2  <= pb_s1;
   end

   // Bus cycle engine: five phases, AS in 0, DS in 2..4
   always_comb
   begin
      next_phase     = phase;
      next_active    = active;
      next_kind      = kind;
      next_mode      = mode;
      next_cyc_addr  = cyc_addr;
      next_cyc_wdata = cyc_wdata;
      next_cyc_write = cyc_write;
      next_cyc_fetch = cyc_fetch;
      next_cyc_irq   = cyc_irq;
      next_pend      = pend;
      next_p_addr    = p_addr;
      next_p_wdata   = p_wdata;
      next_p_write   = p_write;
      next_p_fetch   = p_fetch;
      next_p_irq     = p_irq;
      next_ack       = 1'b0;
      next_rdata     = cpu_rdata;
      next_start     = start_addr;
      next_sv        = start_valid;
      mem_we         = 1'b0;
      // Capture a request while the holding slot is free
      if (cpu_req && !pend)
      begin
         next_pend    = 1'b1;
         next_p_addr  = cpu_addr;
         next_p_wdata = cpu_wdata;
         next_p_write = cpu_write;
         next_p_fetch = cpu_fetch;
         next_p_irq   = cpu_irq_seq;
      end
      if (phase != MBPD_PH_LAST)
      begin
         next_phase = phase + 3'h1;
      end
      else
      begin
         next_phase = MBPD_PH_AS;
         // Close the running cycle
         if (active)
         begin
            case (kind)
               K_VEC:
               begin
                  if (mode == M_VEC_HI)
                  begin
                     next_start[AW-1:8] = bus_s2[AW-9:0];
                     next_mode = M_VEC_LO;
                  end
                  else
                  begin
                     next_start[7:0] = bus_s2;
                     next_mode = M_RUN;
                     next_sv   = 1'b1;
                  end
               end
               K_CPU:
               begin
                  next_ack = 1'b1;
                  // On-chip reads ignore the bus data
                  next_rdata = is_int(cyc_addr) ? int_rd(cyc_addr[6:0])
                                                : bus_s2;
                  mem_we = cyc_write && is_int(cyc_addr);
               end
               default: ;
            endcase
         end
         // Open the next cycle; halted cores issue none
         if (cpu_halt)
         begin
            next_active = 1'b0;
         end
         else
         begin
            next_active = 1'b1;
            if (next_mode != M_RUN)
            begin
               next_kind      = K_VEC;
               next_cyc_addr  = (next_mode == M_VEC_HI) ? VEC_HI_A
                                                        : VEC_LO_A;
               next_cyc_write = 1'b0;
               next_cyc_fetch = 1'b0;
               next_cyc_irq   = 1'b0;
            end
            else if (pend)
            begin
               next_kind      = K_CPU;
               next_pend      = 1'b0;
               next_cyc_addr  = p_addr;
               next_cyc_wdata = p_wdata;
               next_cyc_write = p_write;
               next_cyc_fetch = p_fetch;
               next_cyc_irq   = p_irq;
            end
            else
            begin
               // Idle: redundant read keeps the strobes running
               next_kind      = K_DUMMY;
               next_cyc_write = 1'b0;
               next_cyc_fetch = 1'b0;
            end
         end
      end
      next_busy = next_pend || (next_active && next_kind == K_CPU);
      // Pin values follow the next phase so outputs come from flops
      next_as = next_active && next_phase == MBPD_PH_AS;
      next_ds = next_active && next_phase >= MBPD_PH_DS;
      next_rw = !(next_active && next_cyc_write
                  && next_phase != MBPD_PH_AS);
      next_li = next_active && next_cyc_fetch && !next_cyc_irq
                && next_phase != MBPD_PH_AS;
      next_bout = (next_phase < MBPD_PH_DS) ? next_cyc_addr[7:0]
                                            : next_cyc_wdata;
      next_boe = (next_active && (next_phase < MBPD_PH_DS
                  || next_cyc_write)) ? 8'hff : 8'h00;
   end

   // Control registers
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         phase       <= MBPD_PH_LAST;
         active      <= 1'b0;
         kind        <= K_DUMMY;
         mode        <= M_VEC_HI;
         cyc_addr    <= '0;
         cyc_wdata   <= 8'h00;
         cyc_write   <= 1'b0;
         cyc_fetch   <= 1'b0;
         cyc_irq     <= 1'b0;
         pend        <= 1'b0;
         p_addr      <= '0;
         p_wdata     <= 8'h00;
         p_write     <= 1'b0;
         p_fetch     <= 1'b0;
         p_irq       <= 1'b0;
         cpu_busy    <= 1'b0;
         cpu_ack     <= 1'b0;
         cpu_rdata   <= 8'h00;
         start_addr  <= '0;
         start_valid <= 1'b0;
         addr_strobe <= 1'b0;
         data_strobe <= 1'b0;
         read_write  <= 1'b1;
         high_addr_lines           <= '0;
         muxed_addr_data_lines_out <= 8'h00;
         muxed_addr_data_lines_oe  <= 8'h00;
         opcode_fetch_flag         <= 1'b0;
      end
      else
      begin
         phase       <= next_phase;
         active      <= next_active;
         kind        <= next_kind;
         mode        <= next_mode;
         cyc_addr    <= next_cyc_addr;
         cyc_wdata   <= next_cyc_wdata;
         cyc_write   <= next_cyc_write;
         cyc_fetch   <= next_cyc_fetch;
         cyc_irq     <= next_cyc_irq;
         pend        <= next_pend;
         p_addr      <= next_p_addr;
         p_wdata     <= next_p_wdata;
         p_write     <= next_p_write;
         p_fetch     <= next_p_fetch;
         p_irq       <= next_p_irq;
         cpu_busy    <= next_busy;
         cpu_ack     <= next_ack;
         cpu_rdata   <= next_rdata;
         start_addr  <= next_start;
         start_valid <= next_sv;
         addr_strobe <= next_as;
         data_strobe <= next_ds;
         read_write  <= next_rw;
         high_addr_lines           <= next_cyc_addr[AW-1:8];
         muxed_addr_data_lines_out <= next_bout;
         muxed_addr_data_lines_oe  <= next_boe;
         opcode_fetch_flag         <= next_li;
      end
   end

   // On-chip store: ports latch every write whatever the direction
   always_comb
   begin
      next_ddr_a = ddr_a;
      next_ddr_b = ddr_b;
      next_dat_a = dat_a;
      next_dat_b = dat_b;
      next_tmr0  = tmr0;
      next_tmr1  = tmr1;
      if (mem_we)
      begin
         case (cyc_addr[6:0])
            MBPD_A_PORTA: next_dat_a = cyc_wdata;
            MBPD_A_PORTB: next_dat_b = cyc_wdata;
            MBPD_A_DDRA:  next_ddr_a = cyc_wdata;
            MBPD_A_DDRB:  next_ddr_b = cyc_wdata;
            MBPD_A_TMR0:  next_tmr0  = cyc_wdata;
            MBPD_A_TMR1:  next_tmr1  = cyc_wdata;
            default: ;
         endcase
      end
   end

   // Direction clears on reset; data latches and RAM keep their value
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         ddr_a <= MBPD_DDR_RST;
         ddr_b <= MBPD_DDR_RST;
      end
      else
      begin
         ddr_a <= next_ddr_a;
         ddr_b <= next_ddr_b;
      end
      dat_a <= next_dat_a;
      dat_b <= next_dat_b;
      tmr0  <= next_tmr0;
      tmr1  <= next_tmr1;
      if (mem_we && cyc_addr[6:0] >= MBPD_RAM_BASE)
      begin
         ram[cyc_addr[6:0] - MBPD_RAM_BASE] <= cyc_wdata;
      end
   end

   // Pins drive the latch only where the direction bit is set
   always_comb
   begin
      port_a_pins_out = dat_a;
      port_b_pins_out = dat_b;
      port_a_pins_oe  = ddr_a;
      port_b_pins_oe  = ddr_b;
   end

   a_as_period: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(addr_strobe) ##1 !cpu_halt[*4] |=> addr_strobe)
      else $error("address strobe not every fifth clock");
   a_ds_after_as: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(addr_strobe) |=> data_strobe[*3] ##1 !data_strobe)
      else $error("data strobe not three phases after address");
   a_rw_before_ds: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(read_write) |-> !data_strobe ##1 data_strobe)
      else $error("write level not set before data strobe");
   a_rw_idle_high: assert property (@(posedge clk_sys) disable iff (reset)
      addr_strobe |-> read_write)
      else $error("read_write not idle high in address phase");
   a_halt_quiet: assert property (@(posedge clk_sys) disable iff (reset)
      cpu_halt[*6] |=> !addr_strobe && !data_strobe)
      else $error("strobes active while halted");
   a_ddr_reset: assert property (@(posedge clk_sys)
      reset |=> port_a_pins_oe == 8'h00 && port_b_pins_oe == 8'h00)
      else $error("direction not cleared by reset");
   a_li_irq_low: assert property (@(posedge clk_sys) disable iff (reset)
      cyc_irq && active |-> !opcode_fetch_flag)
      else $error("fetch flag high during interrupt service");
   a_hi_addr_hold: assert property (@(posedge clk_sys) disable iff (reset)
      data_strobe |-> $stable(high_addr_lines))
      else $error("high address moved in data phase");
   a_vec_first: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(reset) |=> addr_strobe && high_addr_lines == VEC_HI_A[AW-1:8]
      && muxed_addr_data_lines_out == VEC_HI_A[7:0])
      else $error("first cycle after reset not the vector");

endmodule

// file: tb/mbpd_ext_mem.sv
// Purpose: External memory model behind the multiplexed address/data bus
// Assumes: Bus level is resolved outside; clock samples the write data
// Notes:   Fills every byte with a pattern, so vector bytes exist on start

`timescale 1ns/1ps

module mbpd_ext_mem
#(
   parameter int AW = 13                      // Address width
)
(
   input  wire logic          clk_sys,        // Oscillator clock
   input  wire logic          addr_strobe,    // Address strobe
   input  wire logic          data_strobe,    // Data strobe
   input  wire logic          read_write,     // High read, low write
   input  wire logic [AW-9:0] high_addr,      // Upper address lines
   input  wire logic [7:0]    bus_in,         // Resolved bus level
   output logic      [7:0]    bus_out,        // Read data
   output logic               bus_oe          // Model drives the bus
);
   logic [7:0]    mem [0:(1<<AW)-1];          // Storage, vectors at the top
   logic [7:0]    low_addr;                   // Latched low address byte
   logic [AW-1:0] full_addr;                  // Rebuilt address

   // Pattern fill; the top two bytes serve as vector contents
   initial
   begin
      for (int i = 0; i < (1 << AW); i++)
         mem[i] = 8'(i * 7 + 3);
   end

   // Low byte stays valid until the data strobe rises; grab it at the strobe fall
   always @(negedge addr_strobe)
      low_addr <= bus_in;

   assign full_addr = {high_addr, low_addr};

   // Answer every read strobe; extra reads have no side effect
   assign bus_oe  = data_strobe & read_write;
   assign bus_out = mem[full_addr];

   // Sample before the edge so a late strobe fall cannot store the address
   always @(posedge clk_sys)
      if (data_strobe && !read_write)
         mem[full_addr] <= bus_in;
endmodule

// file: tb/muxed_bus_ports_decode_test.sv
// Purpose: Self-checking bench for the bus master, decode and ports
// Assumes: Inputs change on the falling clock edge only
// Notes:   Released bus lines toggle each cycle to expose stale sampling

`timescale 1ns/1ps

module muxed_bus_ports_decode_test;
   import mbpd_pkg::*;
   localparam int AW    = MBPD_AW_DEF;        // Address width
   localparam int LIMIT = 20000;              // Run ceiling in cycles

   logic          clk_sys     = 1'b0;         // Oscillator clock
   logic          reset       = 1'b1;         // Sync reset
   logic          cpu_req     = 1'b0;         // Request pulse
   logic          cpu_write   = 1'b0;         // Write request
   logic          cpu_fetch   = 1'b0;         // Fetch request
   logic          cpu_irq_seq = 1'b0;         // Interrupt servicing
   logic          cpu_halt    = 1'b0;         // Wait or stop
   logic [AW-1:0] cpu_addr    = '0;           // Request address
   logic [7:0]    cpu_wdata   = 8'h00;        // Request data
   logic [7:0]    pa_drv      = 8'h00;        // Outside drive on port A
   logic [7:0]    pb_drv      = 8'h00;        // Outside drive on port B
   logic          cpu_busy, cpu_ack, start_valid, addr_strobe;
   logic          data_strobe, read_write, mem_oe, opcode_fetch_flag;
   logic [7:0]    cpu_rdata, md_out, md_oe, mem_out, pa_out, pa_oe;
   logic [7:0]    pb_out, pb_oe, pa_lvl, pb_lvl, bus_lvl;
   logic [7:0]    bus_prev    = 8'h00;        // Last bus level
   logic [AW-1:0] start_addr;                 // Fetched start vector
   logic [AW-9:0] high_addr_lines;            // Upper address
   logic          as_prev     = 1'b0;         // Strobe history
   logic          ds_prev     = 1'b0;
   int            as_rises    = 0;            // Strobe rise counters
   int            ds_rises    = 0;
   int            li_ds       = 0;            // Fetch flag over data strobe
   int            errors      = 0;
   int            checks      = 0;
   int            cycles      = 0;

   always #50 clk_sys = ~clk_sys;

   // Wire levels: driver wins, else a floating line shows the inverse
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         bus_lvl[i] = md_oe[i] ? md_out[i]
                    : (mem_oe ? mem_out[i] : ~bus_prev[i]);
         pa_lvl[i]  = pa_oe[i] ? pa_out[i] : pa_drv[i];
         pb_lvl[i]  = pb_oe[i] ? pb_out[i] : pb_drv[i];
      end
   end

   // Strobe counting and the run ceiling
   always @(posedge clk_sys)
   begin
      bus_prev <= bus_lvl;
      as_prev  <= addr_strobe;
      ds_prev  <= data_strobe;
      if (addr_strobe === 1'b1 && as_prev === 1'b0)
         as_rises <= as_rises + 1;
      if (data_strobe === 1'b1 && ds_prev === 1'b0)
         ds_rises <= ds_rises + 1;
      if (opcode_fetch_flag === 1'b1 && data_strobe === 1'b1)
         li_ds <= li_ds + 1;
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         errors = errors + 1;
         $display("Error run ceiling reached");
         finish_test();
      end
   end

   mbpd_core u_mbpd_core (
      .clk_sys(clk_sys), .reset(reset), .cpu_req(cpu_req),
      .cpu_write(cpu_write), .cpu_fetch(cpu_fetch),
      .cpu_irq_seq(cpu_irq_seq), .cpu_halt(cpu_halt),
      .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_busy(cpu_busy),
      .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .start_addr(start_addr),
      .start_valid(start_valid), .addr_strobe(addr_strobe),
      .data_strobe(data_strobe), .read_write(read_write),
      .high_addr_lines(high_addr_lines),
      .opcode_fetch_flag(opcode_fetch_flag),
      .muxed_addr_data_lines_in(bus_lvl),
      .muxed_addr_data_lines_out(md_out), .muxed_addr_data_lines_oe(md_oe),
      .port_a_pins_in(pa_lvl), .port_a_pins_out(pa_out),
      .port_a_pins_oe(pa_oe), .port_b_pins_in(pb_lvl),
      .port_b_pins_out(pb_out), .port_b_pins_oe(pb_oe));

   mbpd_ext_mem #(.AW(AW)) u_mbpd_ext_mem (
      .clk_sys(clk_sys), .addr_strobe(addr_strobe),
      .data_strobe(data_strobe), .read_write(read_write),
      .high_addr(high_addr_lines), .bus_in(bus_lvl),
      .bus_out(mem_out), .bus_oe(mem_oe));

   // Pattern the outside memory starts with
   function automatic logic [7:0] pat(int i);
      return 8'(i * 7 + 3);
   endfunction

   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      checks = checks + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One request, waited for under a bound; fetch marks every read
   task automatic cpu_op(input logic w, input logic [AW-1:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (cpu_busy !== 1'b0 && n < 100)
      begin
         @(negedge clk_sys);
         n++;
      end
      cpu_req   = 1'b1;
      cpu_write = w;
      cpu_fetch = ~w;
      cpu_addr  = a;
      cpu_wdata = d;
      @(negedge clk_sys);
      cpu_req = 1'b0;
      check("busy held", 16'h1, {15'h0, cpu_busy});
      while (cpu_ack !== 1'b1 && n < 100)
      begin
         @(negedge clk_sys);
         n++;
      end
      check("ack", 16'h1, {15'h0, cpu_ack});
      check("busy free", 16'h0, {15'h0, cpu_busy});
      q = cpu_rdata;
   endtask

   // Reset of 20 cycles, then the start vector fetch
   task automatic do_reset();
      reset = 1'b1;
      repeat (20) @(negedge clk_sys);
      check("strobes in reset", 16'h0, {addr_strobe, data_strobe});
      check("rw in reset", 16'h1, {15'h0, read_write});
      check("port dir", 16'h0, {pa_oe, pb_oe});
      reset = 1'b0;
      for (int n = 0; n < 40 && start_valid !== 1'b1; n++)
         @(negedge clk_sys);
      check("start vector", 16'(AW'({pat(8190), pat(8191)})),
            16'(start_addr));
   endtask

   // Free-running strobes at one fifth of the clock, stopped by halt
   task automatic test_rate();
      int a0, d0;
      a0 = as_rises;
      d0 = ds_rises;
      repeat (50) @(negedge clk_sys);
      check("as rate", 16'd10, 16'(as_rises - a0));
      check("ds rate", 16'd10, 16'(ds_rises - d0));
      cpu_halt = 1'b1;
      repeat (10) @(negedge clk_sys);
      a0 = as_rises;
      repeat (30) @(negedge clk_sys);
      check("as halted", 16'd0, 16'(as_rises - a0));
      check("halt lines", 16'h0100, {7'h0, read_write, md_oe});
      cpu_halt = 1'b0;
   endtask

   // Outside writes and reads, the ten low outside slots and page one
   task automatic test_ext();
      logic [7:0] q;
      logic [7:0] slots [10] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h0a,
                                 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
      cpu_op(1'b1, 13'h0123, 8'h5c, q);
      check("ext write", 16'h5c, 16'(u_mbpd_ext_mem.mem[13'h0123]));
      cpu_op(1'b0, 13'h0123, 8'h00, q);
      check("ext read", 16'h5c, 16'(q));
      foreach (slots[i])
      begin
         cpu_op(1'b0, 13'(slots[i]), 8'h00, q);
         check("low ext slot", 16'(pat(slots[i])), 16'(q));
      end
      cpu_op(1'b0, 13'h0080, 8'h00, q);
      check("first ext", 16'(pat(128)), 16'(q));
   endtask

   // On-chip RAM: write mirrored outside, read ignores the bus
   task automatic test_int();
      logic [7:0] q;
      cpu_op(1'b1, 13'h007f, 8'ha7, q);
      check("mirror", 16'ha7, 16'(u_mbpd_ext_mem.mem[13'h007f]));
      u_mbpd_ext_mem.mem[13'h007f] = 8'h00;
      cpu_op(1'b0, 13'h007f, 8'h00, q);
      check("int read", 16'ha7, 16'(q));
   endtask

   // Fetch flag overlaps the three strobe phases, never in interrupt service
   task automatic test_fetch();
      logic [7:0] q;
      int l0;
      l0 = li_ds;
      cpu_op(1'b0, 13'h0123, 8'h00, q);
      check("fetch flag", 16'd3, 16'(li_ds - l0));
      cpu_irq_seq = 1'b1;
      l0 = li_ds;
      cpu_op(1'b0, 13'h0123, 8'h00, q);
      cpu_irq_seq = 1'b0;
      check("irq fetch flag", 16'd0, 16'(li_ds - l0));
      check("irq read", 16'h5c, 16'(q));
   endtask

   // Direction da and db on the two ports; reads merge latch and pins
   task automatic test_ports(logic [7:0] da, logic [7:0] db);
      logic [7:0] q;
      pa_drv = 8'h3c;
      pb_drv = 8'hc3;
      cpu_op(1'b1, 13'h0004, da, q);
      cpu_op(1'b1, 13'h0005, db, q);
      cpu_op(1'b1, 13'h0000, 8'ha5, q);
      cpu_op(1'b1, 13'h0001, 8'h96, q);
      check("port a pins", 16'({da, 8'ha5}), {pa_oe, pa_out});
      check("port b pins", 16'({db, 8'h96}), {pb_oe, pb_out});
      cpu_op(1'b0, 13'h0000, 8'h00, q);
      check("port a read", 16'((8'ha5 & da) | (8'h3c & ~da)), 16'(q));
      cpu_op(1'b0, 13'h0001, 8'h00, q);
      check("port b read", 16'((8'h96 & db) | (8'hc3 & ~db)), 16'(q));
      cpu_op(1'b0, 13'h0005, 8'h00, q);
      check("dir b read", 16'(db), 16'(q));
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence; second reset must keep the port latches
   initial
   begin
      do_reset();
      test_rate();
      test_ext();
      test_int();
      test_fetch();
      test_ports(8'h0f, 8'hf0);
      do_reset();
      check("latches kept", 16'ha596, {pa_out, pb_out});
      test_ports(8'hff, 8'h00);
      finish_test();
   end
endmodule
